// ### include/dram_test_regs.svh
// timing and size constants of the refresh counter test controller
// assumes a 10 MHz system clock driving both the sequencer and the memory pins
`ifndef DRAM_TEST_REGS_SVH
`define DRAM_TEST_REGS_SVH

`define CLK_PERIOD_NS 100
`define PAUSE_TIME_US 200
// least time, rounded up to whole cycles
`define PAUSE_CYCLES ((`PAUSE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAUSE_CNT_W 12
`define INIT_LAST 3'h7
`define ROW_LAST 9'h1ff
`define FIRST_PATTERN 16'h0000

`endif

// ### include/dram_test_pkg.sv
// types shared by the counter test sequencer and the memory cycle engine
// assumes the constants header is included by each user
package dram_test_pkg;

  typedef enum logic [2:0] {
    OP_RAS_ONLY = 3'h0,
    OP_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_CBR_WRITE = 3'h3,
    OP_CBR_READ = 3'h4
  } op_type;

  typedef enum logic [6:0] {
    CY_IDLE = 7'h01,
    CY_ROW = 7'h02,
    CY_COL = 7'h04,
    CY_PRE = 7'h08,
    CY_CBR_CAS = 7'h10,
    CY_CBR_RAS = 7'h20,
    CY_CBR_GAP = 7'h40
  } cycle_state_type;

  typedef enum logic [8:0] {
    T_PAUSE = 9'h001,
    T_INIT = 9'h002,
    T_IDLE = 9'h004,
    T_NORM = 9'h008,
    T_CBR_WR = 9'h010,
    T_N_RD = 9'h020,
    T_N_WR = 9'h040,
    T_CBR_RD = 9'h080,
    T_DONE = 9'h100
  } test_state_type;

endpackage : dram_test_pkg

// ### verilog/dram_cycle.sv
// one memory cycle on the strobe pins: row-only refresh, read, early write,
// and the refresh counter test access; every pin is a flip-flop
// assumes one clock period (100 ns) covers each strobe phase of the part
`timescale 1ns/1ps
`include "dram_test_regs.svh"

module dram_cycle
  import dram_test_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire op_type op,
  input wire logic [8:0] row,
  input wire logic [8:0] col,
  input wire logic [15:0] wdata,
  output logic cycle_done,
  output logic [15:0] rdata,
  output logic ras_b,
  output logic lower_byte_column_strobe_b,
  output logic upper_byte_column_strobe_b,
  output logic we_b,
  output logic oe_b,
  output logic [8:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);

  cycle_state_type state, next_state;
  op_type cur_op;
  logic [8:0] cur_row, cur_col;
  logic [15:0] cur_wdata;

  // the request is decoded in the cycle it arrives so pins move on the next edge
  wire take = (state == CY_IDLE) && start;
  wire op_type src_op = take ? op : cur_op;
  wire [8:0] src_row = take ? row : cur_row;
  wire [8:0] src_col = take ? col : cur_col;
  wire [15:0] src_wdata = take ? wdata : cur_wdata;
  wire is_cbr = (src_op == OP_CBR_WRITE) || (src_op == OP_CBR_READ);
  wire is_wr = (src_op == OP_WRITE) || (src_op == OP_CBR_WRITE);

  always_comb begin
    next_state = state;
    case (state)
      CY_IDLE: if (start) next_state = is_cbr ? CY_CBR_CAS : CY_ROW;
      CY_ROW: next_state = (src_op == OP_RAS_ONLY) ? CY_PRE : CY_COL;
      CY_CBR_CAS: next_state = CY_CBR_RAS;
      CY_CBR_RAS: next_state = CY_CBR_GAP;
      CY_CBR_GAP: next_state = CY_COL;
      CY_COL: next_state = CY_PRE;
      CY_PRE: next_state = CY_IDLE;
      default: next_state = CY_IDLE;
    endcase
  end

  // in a test access, column strobes fall before the row strobe, rise, then fall again for the access
  wire next_ras_low = (next_state == CY_ROW) || (next_state == CY_COL) ||
                      (next_state == CY_CBR_RAS) || (next_state == CY_CBR_GAP);
  // both byte strobes move together so all sixteen lanes take part
  wire next_cas_low = (next_state == CY_CBR_CAS) || (next_state == CY_CBR_RAS) || (next_state == CY_COL);
  // write enable is low before the column strobe falls: early write, outputs stay off
  wire next_we_low = is_wr && ((next_state == CY_ROW) || (next_state == CY_CBR_GAP) || (next_state == CY_COL));
  wire next_oe_low = !is_wr && (next_state == CY_COL);
  // data is held one cycle past the column strobe rise for the hold time
  wire next_dq_oe = is_wr && ((next_state == CY_ROW) || (next_state == CY_CBR_GAP) ||
                              (next_state == CY_COL) || (next_state == CY_PRE));
  // the row comes from the part's counter in a test access, so only the column is driven
  wire [8:0] next_addr = (next_state == CY_ROW) ? src_row : src_col;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CY_IDLE;
      cur_op <= OP_RAS_ONLY;
      cur_row <= 9'h000;
      cur_col <= 9'h000;
      cur_wdata <= 16'h0000;
    end else begin
      state <= next_state;
      cur_op <= src_op;
      cur_row <= src_row;
      cur_col <= src_col;
      cur_wdata <= src_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ras_b <= 1'b1;
      lower_byte_column_strobe_b <= 1'b1;
      upper_byte_column_strobe_b <= 1'b1;
      we_b <= 1'b1;
      oe_b <= 1'b1;
      addr <= 9'h000;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      ras_b <= !next_ras_low;
      lower_byte_column_strobe_b <= !next_cas_low;
      upper_byte_column_strobe_b <= !next_cas_low;
      we_b <= !next_we_low;
      oe_b <= !next_oe_low;
      addr <= next_addr;
      dq_out <= src_wdata;
      dq_oe <= next_dq_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
      cycle_done <= 1'b0;
    end else begin
      if ((state == CY_COL) && !is_wr) rdata <= dq_in;
      cycle_done <= (state == CY_PRE);
    end
  end

  // second column fall while the row strobe is held low after a refresh
  cbr_second_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($fell(ras_b) && !lower_byte_column_strobe_b) |=> lower_byte_column_strobe_b ##1
      (!lower_byte_column_strobe_b && !ras_b && addr == cur_col))
    else $error("counter test access lacks second column strobe fall");

  early_write_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($fell(lower_byte_column_strobe_b) && !ras_b && is_wr) |-> (!we_b && oe_b && dq_oe))
    else $error("write strobe not low before column strobe");

  standby_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == CY_IDLE && $past(state) == CY_IDLE) |->
      (ras_b && lower_byte_column_strobe_b && upper_byte_column_strobe_b && !dq_oe))
    else $error("pins not in standby while idle");

  lanes_together_a: assert property (@(posedge clk) disable iff (!rst_b)
    lower_byte_column_strobe_b == upper_byte_column_strobe_b)
    else $error("byte column strobes differ");

endmodule : dram_cycle

// ### verilog/dram_counter_test.sv
// memory controller that powers up an asynchronous 16-bit DRAM and runs the
// refresh counter test sequence through the strobe pins
// assumes the part answers read data within one 100 ns clock of its column strobe
`timescale 1ns/1ps
`include "dram_test_regs.svh"

// How it works
// - the test opens with eight row-only refresh cycles to bring the counter to a known state.
// - one fixed column address is used for every access of the test.
// - counter test cycles write the test data to all 512 rows at that column.
// - normal reads check that data and normal writes then put the inverse there.
// - counter test reads check the inverse at all 512 locations.
// - the data is then inverted and the write, read-rewrite and counter read steps repeat.
// - after power-up the strobes stay high 200 us, then eight row-only cycles precede use.
module dram_counter_test
  import dram_test_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [8:0] test_column,
  output logic ready,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [8:0] fail_row,
  output logic ras_b,
  output logic lower_byte_column_strobe_b,
  output logic upper_byte_column_strobe_b,
  output logic we_b,
  output logic oe_b,
  output logic [8:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);

  test_state_type state, next_state;
  logic [`PAUSE_CNT_W-1:0] pause_cnt;
  logic [2:0] run_cnt;
  logic [8:0] idx;
  logic [8:0] col;
  logic [15:0] pattern;
  logic second_pass;
  logic waiting;
  logic cyc_start;
  op_type cyc_op;
  logic [8:0] cyc_row;
  logic [15:0] cyc_wdata;
  logic cycle_done;
  logic [15:0] rdata;

  wire running = (state == T_INIT) || (state == T_NORM) || (state == T_CBR_WR) ||
                 (state == T_N_RD) || (state == T_N_WR) || (state == T_CBR_RD);
  wire issue = running && !waiting;
  wire step = waiting && cycle_done;
  wire run_last = (run_cnt == `INIT_LAST);
  wire idx_last = (idx == `ROW_LAST);
  wire pause_end = (pause_cnt == `PAUSE_CNT_W'(`PAUSE_CYCLES - 1));
  // the counter read checks the data that the normal pass rewrote
  wire [15:0] expect_data = (state == T_CBR_RD) ? ~pattern : pattern;
  wire mismatch = (rdata != expect_data);
  wire check = step && ((state == T_N_RD) || (state == T_CBR_RD));

  // row-only cycles walk a small row range, sweeps walk all rows
  wire op_type issue_op = (state == T_CBR_WR) ? OP_CBR_WRITE :
                          (state == T_N_RD) ? OP_READ :
                          (state == T_N_WR) ? OP_WRITE :
                          (state == T_CBR_RD) ? OP_CBR_READ : OP_RAS_ONLY;
  wire [8:0] issue_row = ((state == T_INIT) || (state == T_NORM)) ? {6'h00, run_cnt} : idx;
  wire [15:0] issue_wdata = (state == T_N_WR) ? ~pattern : pattern;

  always_comb begin
    next_state = state;
    case (state)
      T_PAUSE: if (pause_end) next_state = T_INIT;
      T_INIT: if (step && run_last) next_state = T_IDLE;
      T_IDLE: if (start) next_state = T_NORM;
      T_NORM: if (step && run_last) next_state = T_CBR_WR;
      T_CBR_WR: if (step && idx_last) next_state = T_N_RD;
      T_N_RD: if (step) next_state = mismatch ? T_DONE : T_N_WR;
      T_N_WR: if (step) next_state = idx_last ? T_CBR_RD : T_N_RD;
      T_CBR_RD: begin
        if (step) begin
          if (mismatch || (idx_last && second_pass)) next_state = T_DONE;
          else if (idx_last) next_state = T_CBR_WR;
        end
      end
      T_DONE: next_state = T_IDLE;
      default: next_state = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= T_PAUSE;
      pause_cnt <= `PAUSE_CNT_W'(0);
    end else begin
      state <= next_state;
      if (state == T_PAUSE) pause_cnt <= pause_cnt + `PAUSE_CNT_W'(1);
    end
  end

  // counters wrap by width: eight row-only cycles and 512 rows each end at zero again
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt <= 3'h0;
      idx <= 9'h000;
    end else begin
      if (step && ((state == T_INIT) || (state == T_NORM))) run_cnt <= run_cnt + 3'h1;
      if (step && ((state == T_CBR_WR) || (state == T_N_WR) || (state == T_CBR_RD))) idx <= idx + 9'h001;
      if (next_state == T_DONE) idx <= 9'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      col <= 9'h000;
      pattern <= `FIRST_PATTERN;
      second_pass <= 1'b0;
    end else if (state == T_IDLE && start) begin
      col <= test_column;
      pattern <= `FIRST_PATTERN;
      second_pass <= 1'b0;
    end else if (state == T_CBR_RD && next_state == T_CBR_WR) begin
      pattern <= ~pattern;
      second_pass <= 1'b1;
    end
  end

  // one cycle in flight at a time; the engine is idle whenever waiting is clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waiting <= 1'b0;
      cyc_start <= 1'b0;
      cyc_op <= OP_RAS_ONLY;
      cyc_row <= 9'h000;
      cyc_wdata <= 16'h0000;
    end else begin
      cyc_start <= issue;
      if (issue) begin
        waiting <= 1'b1;
        cyc_op <= issue_op;
        cyc_row <= issue_row;
        cyc_wdata <= issue_wdata;
      end else if (step) begin
        waiting <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      fail_row <= 9'h000;
    end else begin
      ready <= (next_state == T_IDLE);
      busy <= running || (next_state != T_IDLE && next_state != T_PAUSE && next_state != T_INIT);
      done <= (next_state == T_DONE);
      if (state == T_IDLE && start) fail <= 1'b0;
      else if (check && mismatch) begin
        fail <= 1'b1;
        fail_row <= idx;
      end
    end
  end

  dram_cycle engine (
    .clk(clk),
    .rst_b(rst_b),
    .start(cyc_start),
    .op(cyc_op),
    .row(cyc_row),
    .col(col),
    .wdata(cyc_wdata),
    .cycle_done(cycle_done),
    .rdata(rdata),
    .ras_b(ras_b),
    .lower_byte_column_strobe_b(lower_byte_column_strobe_b),
    .upper_byte_column_strobe_b(upper_byte_column_strobe_b),
    .we_b(we_b),
    .oe_b(oe_b),
    .addr(addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dq_in(dq_in)
  );

  // helper: row-only cycles completed in the current init or normalise phase
  logic [3:0] ras_only_seen;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ras_only_seen <= 4'h0;
    else if (state == T_IDLE) ras_only_seen <= 4'h0;
    else if (step && ((state == T_INIT) || (state == T_NORM))) ras_only_seen <= ras_only_seen + 4'h1;
  end

  pause_strobes_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == T_PAUSE) |-> (ras_b && lower_byte_column_strobe_b && upper_byte_column_strobe_b))
    else $error("strobes not high during power-up pause");

  pause_length_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == T_INIT && $past(state) == T_PAUSE) |-> ($past(pause_cnt) == `PAUSE_CNT_W'(`PAUSE_CYCLES - 1)))
    else $error("power-up pause has wrong length");

  init_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == T_INIT && next_state == T_IDLE) |-> (ras_only_seen == 4'h7))
    else $error("init did not issue eight row-only cycles");

  normalise_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == T_NORM && next_state == T_CBR_WR) |-> (ras_only_seen == 4'h7))
    else $error("normalise did not issue eight row-only cycles");

  fixed_column_a: assert property (@(posedge clk) disable iff (!rst_b)
    (running && state != T_INIT && $past(running)) |-> $stable(col))
    else $error("column changed during test");

  sweep_complete_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == T_CBR_WR && next_state == T_N_RD) |-> (idx == 9'h1ff && cyc_op == OP_CBR_WRITE))
    else $error("counter write sweep ended early");

  cbr_write_data_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cyc_start && cyc_op == OP_CBR_WRITE) |-> (cyc_wdata == pattern) ##4 (dq_oe && dq_out == pattern))
    else $error("counter write data wrong");

  rewrite_inverse_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cyc_start && cyc_op == OP_WRITE) |-> (cyc_wdata == ~pattern && $past(state) == T_N_WR))
    else $error("normal rewrite data not inverse");

  invert_repeat_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(second_pass) |-> (state == T_CBR_WR && pattern == ~`FIRST_PATTERN && idx == 9'h000))
    else $error("second pass not inverted");

  full_pass_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(done) && !fail && second_pass);
  fail_seen_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(fail));
  second_pass_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(second_pass));
  cbr_read_c: cover property (@(posedge clk) disable iff (!rst_b) cyc_start && cyc_op == OP_CBR_READ);

endmodule : dram_counter_test

// ### tb/dram_device_model.sv
// behavioural 256k x 16 dram with a column-before-row refresh counter
// assumes the controller's pins are flops of clk; clk here only paces sampling
`timescale 1ns/1ps
module dram_device_model #(
  parameter logic [8:0] COUNTER_START = 9'h0a3
) (
  input wire logic clk,
  input wire logic ras_b,
  input wire logic lower_byte_column_strobe_b,
  input wire logic upper_byte_column_strobe_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic [8:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic freeze_counter,
  output logic [15:0] dq_in,
  output int n_row_only,
  output int n_cbr_wr,
  output int n_cbr_rd,
  output int n_norm_rd,
  output int n_norm_wr,
  output int n_page
);
  logic [15:0] mem [logic [17:0]];
  logic [8:0] counter = COUNTER_START;
  logic [8:0] row_q = 9'h000;
  logic p_ras = 1'b1;
  logic p_cas = 1'b1;
  logic column_before_row_refresh = 1'b0;
  logic rearm = 1'b0;
  logic used = 1'b0;
  logic [15:0] merged;
  logic [15:0] cell_word;
  wire cas_hi = lower_byte_column_strobe_b & upper_byte_column_strobe_b;
  // after a refresh only a second strobe fall opens an access
  wire access_on = !ras_b && !cas_hi && (!column_before_row_refresh || rearm);
  wire [8:0] acc_row = column_before_row_refresh ? counter : row_q;
  wire read_on = access_on && !oe_b && we_b;

  // cells never decay here, so the side refresh of an access needs no logic
  function automatic logic [15:0] peek(input logic [8:0] r, input logic [8:0] c);
    if (mem.exists({r, c}))
      return mem[{r, c}];
    return 16'h5a5a;
  endfunction : peek

  initial begin
    dq_in = 16'h0000;
    {n_row_only, n_cbr_wr, n_cbr_rd, n_norm_rd, n_norm_wr, n_page} = '0;
  end

  // an idle lane shows the inverse of its last value, never a stale match
  always @(negedge clk) begin
    cell_word = peek(acc_row, addr);
    dq_in[7:0] <= (read_on && !lower_byte_column_strobe_b) ? cell_word[7:0] : ~dq_in[7:0];
    dq_in[15:8] <= (read_on && !upper_byte_column_strobe_b) ? cell_word[15:8] : ~dq_in[15:8];
  end

  always @(posedge clk) begin
    if (p_ras && !ras_b) begin
      column_before_row_refresh <= !cas_hi;
      rearm <= 1'b0;
      used <= 1'b0;
      row_q <= addr;
    end
    if (!p_ras && ras_b) begin
      if (!column_before_row_refresh && !used)
        n_row_only <= n_row_only + 1;
      if (column_before_row_refresh && !freeze_counter)
        counter <= counter + 9'h001;
      column_before_row_refresh <= 1'b0;
    end
    if (!ras_b && !p_cas && cas_hi && column_before_row_refresh)
      rearm <= 1'b1;
    // column taken from the pins at the strobe fall
    if (access_on && p_cas) begin
      used <= 1'b1;
      // a second access in one row cycle is page mode, which would skip the side refresh
      if (used && !column_before_row_refresh)
        n_page <= n_page + 1;
      if (!we_b) begin
        merged = peek(acc_row, addr);
        if (!lower_byte_column_strobe_b && dq_oe)
          merged[7:0] = dq_out[7:0];
        if (!upper_byte_column_strobe_b && dq_oe)
          merged[15:8] = dq_out[15:8];
        mem[{acc_row, addr}] = merged;
        if (column_before_row_refresh)
          n_cbr_wr <= n_cbr_wr + 1;
        else
          n_norm_wr <= n_norm_wr + 1;
      end else if (column_before_row_refresh) begin
        n_cbr_rd <= n_cbr_rd + 1;
      end else begin
        n_norm_rd <= n_norm_rd + 1;
      end
    end
    p_ras <= ras_b;
    p_cas <= cas_hi;
  end
endmodule : dram_device_model

// ### tb/test_dram_counter_test.sv
// self-checking bench: controller against the behavioural dram model
// assumes a 10 MHz clock and a watchdog well above one power-up and two test runs
`timescale 1ns/1ps
module test_dram_counter_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic [8:0] test_column = 9'h000;
  logic freeze = 1'b0;
  logic ready, busy, done, fail, ras_b, lcs_b, ucs_b, we_b, oe_b, dq_oe;
  logic [8:0] fail_row, addr;
  logic [15:0] dq_out, dq_in;
  int n_ro, n_cw, n_cr, n_nr, n_nw, n_pg;
  int n_fail = 0;
  int cmp_count = 0;
  logic col_watch = 1'b0;
  logic p_cas_b = 1'b1;

  always #50 clk = ~clk;

  dram_counter_test uut (.clk(clk), .rst_b(rst_b), .start(start), .test_column(test_column), .ready(ready),
    .busy(busy), .done(done), .fail(fail), .fail_row(fail_row), .ras_b(ras_b),
    .lower_byte_column_strobe_b(lcs_b), .upper_byte_column_strobe_b(ucs_b), .we_b(we_b), .oe_b(oe_b),
    .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

  dram_device_model dev (.clk(clk), .ras_b(ras_b), .lower_byte_column_strobe_b(lcs_b),
    .upper_byte_column_strobe_b(ucs_b), .we_b(we_b), .oe_b(oe_b), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .freeze_counter(freeze), .dq_in(dq_in), .n_row_only(n_ro), .n_cbr_wr(n_cw),
    .n_cbr_rd(n_cr), .n_norm_rd(n_nr), .n_norm_wr(n_nw), .n_page(n_pg));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // every column strobe fall must carry the test column
  always @(posedge clk) begin
    if (col_watch && p_cas_b && !(lcs_b & ucs_b))
      check("column address", test_column, addr);
    p_cas_b <= lcs_b & ucs_b;
  end

  task automatic t_reset;
    check("reset pins", 7'h7c, {ras_b, lcs_b, ucs_b, we_b, oe_b, dq_oe, ready});
    check("reset status", 3'h0, {busy, done, fail});
    $display("test reset done");
  endtask : t_reset

  task automatic t_powerup;
    int n;
    logic cas_seen;
    n = 0;
    cas_seen = 1'b0;
    while (ras_b === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      cas_seen |= !(lcs_b & ucs_b);
    end
    check("pause long enough", 1, n >= 2000);
    check("strobes high in pause", 0, cas_seen);
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    check("ready after init", 1, ready);
    check("init row-only cycles", 8, n_ro);
    $display("test powerup done");
  endtask : t_powerup

  task automatic run(input logic [8:0] col);
    int n;
    n = 0;
    @(posedge clk);
    test_column <= col;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    col_watch <= 1'b1;
    repeat (3) @(posedge clk);
    check("busy after start", 1, busy);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    check("done seen", 1, done);
    col_watch <= 1'b0;
    #1;
  endtask : run

  task automatic t_full_run;
    int ro, cw, cr, nr, nw, r;
    logic bad;
    {ro, cw, cr, nr, nw} = {n_ro, n_cw, n_cr, n_nr, n_nw};
    run(9'h0c5);
    check("clean run fail", 0, fail);
    check("normalising cycles", 8, n_ro - ro);
    check("counter writes", 1024, n_cw - cw);
    check("normal reads", 1024, n_nr - nr);
    check("normal writes", 1024, n_nw - nw);
    check("counter reads", 1024, n_cr - cr);
    check("page mode accesses", 0, n_pg);
    bad = 1'b0;
    for (r = 0; r < 512; r++)
      bad |= dev.peek(r[8:0], 9'h0c5) !== 16'h0000;
    check("final zeros all rows", 0, bad);
    @(posedge clk);
    #1;
    check("ready after done", 2'h2, {ready, done});
    $display("test full run done");
  endtask : t_full_run

  task automatic t_fault_run;
    int cw, nr, nw;
    {cw, nr, nw} = {n_cw, n_nr, n_nw};
    @(posedge clk);
    freeze <= 1'b1;
    run(9'h13a);
    check("stuck counter fail", 1, fail);
    check("stuck counter row", 9'h000, fail_row);
    check("counter writes before abort", 512, n_cw - cw);
    check("reads before abort", 1, n_nr - nr);
    check("writes before abort", 0, n_nw - nw);
    $display("test fault run done");
  endtask : t_fault_run

  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    t_reset();
    rst_b <= 1'b1;
    t_powerup();
    t_full_run();
    t_fault_run();
    conclude();
  end
endmodule : test_dram_counter_test
